/* File: rtl/gpd_pkg.sv */
// constants, layouts and read helper for the port b/c/d logic
// assumes an apb master with 32-bit data; one register per aligned word
package gpd_pkg;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_B_DATA   = 6'h01;
    localparam logic [5:0] IDX_C_DATA   = 6'h02;
    localparam logic [5:0] IDX_D_DATA   = 6'h03;
    localparam logic [5:0] IDX_B_DIR    = 6'h05;
    localparam logic [5:0] IDX_C_DIR    = 6'h06;
    localparam logic [5:0] IDX_D_DIR    = 6'h07;
    localparam logic [5:0] IDX_C_PULLUP = 6'h0C;
    localparam logic [5:0] IDX_PERIPH   = 6'h10;
    localparam logic [5:0] IDX_CONV     = 6'h11;

    localparam int B_W = 6;
    localparam int C_W = 2;
    localparam int D_W = 7;

    localparam logic [7:0] DIR_RESET    = 8'h00;
    localparam logic [7:0] PERIPH_RESET = 8'h00;
    localparam logic [2:0] CONV_NONE    = 3'h7;  // no port b pin selected
    localparam int         SYNC_STAGES  = 2;

    // alternate-function control, software visible at IDX_PERIPH
    typedef struct packed {
        logic [1:0] els_t2c0;   // edge_level_select_high/low, pin d6
        logic [1:0] els_t1c1;   // pin d5
        logic [1:0] els_t1c0;   // pin d4
        logic       spi_master_select_bit;
        logic       spi_enable_bit;
    } gpd_periph_t;

    // per-bit read path: latch where output, pin where input
    function automatic logic [7:0] read_mux(input logic [7:0] dir,
                                           input logic [7:0] latch,
                                           input logic [7:0] pin);
        return (dir & latch) | (~dir & pin);
    endfunction

endpackage

/* File: rtl/gpd_sync.sv */
// two-flop synchroniser for a vector of pin levels
// assumes pins change asynchronously to clk
`timescale 1ns/100ps
module gpd_sync #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    // first stage feeds only the second
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

    a_sync_delay: assert property (@(posedge clk) disable iff (reset)
        !$past(reset) && !$past(reset, 2) |-> q == $past(d, 2))
        else $error("synchroniser delay is not two cycles");
endmodule

/* File: rtl/gpd_pin_mux.sv */
// output driver selection for one port: gpio, alternate function, forced input
// assumes alt_oe/alt_out come from the owning peripheral
`timescale 1ns/100ps
module gpd_pin_mux #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] dir,
    input  wire logic [W-1:0] latch,
    input  wire logic [W-1:0] alt_sel,
    input  wire logic [W-1:0] alt_out,
    input  wire logic [W-1:0] alt_oe,
    input  wire logic [W-1:0] force_in,
    output logic      [W-1:0] pin_out,
    output logic      [W-1:0] pin_oe_n
);
    // forced input wins, then peripheral, then direction bit
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (force_in[i]) begin
                pin_out[i]  = 1'b0;
                pin_oe_n[i] = 1'b1;
            end else if (alt_sel[i]) begin
                pin_out[i]  = alt_out[i];
                pin_oe_n[i] = ~alt_oe[i];
            end else begin
                pin_out[i]  = latch[i];
                pin_oe_n[i] = ~dir[i];
            end
        end
    end
endmodule

/* File: rtl/gpd_ports.sv */
// general-purpose port logic for ports b, c and d behind an apb slave
// assumes apb3 master; pins are in/out/oe_n triples resolved outside
`timescale 1ns/100ps
module gpd_ports #(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk,
    input  wire logic              reset,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // port b pins
    input  wire logic [5:0]        pb_in,
    output logic      [5:0]        pb_out,
    output logic      [5:0]        pb_oe_n,
    output logic      [5:0]        pb_analog_sel,
    // port c pins
    input  wire logic [1:0]        pc_in,
    output logic      [1:0]        pc_out,
    output logic      [1:0]        pc_oe_n,
    output logic      [1:0]        pc_pullup_on,
    // port d pins
    input  wire logic [6:0]        pd_in,
    output logic      [6:0]        pd_out,
    output logic      [6:0]        pd_oe_n,
    // peripheral side
    input  wire logic [3:0]        spi_pin_out,
    input  wire logic [3:0]        spi_pin_oe,
    input  wire logic [2:0]        tim_pin_out,
    input  wire logic [2:0]        tim_pin_oe,
    output logic      [6:0]        pd_level,
    output logic                   spi_slave_select_n,
    output logic                   spi_enable,
    output logic                   spi_master
);
    localparam int B_W = gpd_pkg::B_W;
    localparam int C_W = gpd_pkg::C_W;
    localparam int D_W = gpd_pkg::D_W;

    // software state
    logic [B_W-1:0]      port_b_data_r;
    logic [C_W-1:0]      port_c_data_r;
    logic [D_W-1:0]      port_d_data_r;
    logic [B_W-1:0]      port_b_direction_r;
    logic [C_W-1:0]      port_c_direction_r;
    logic [D_W-1:0]      port_d_direction_r;
    logic [C_W-1:0]      port_c_pullup_enable_r;
    gpd_pkg::gpd_periph_t periph_r;
    logic [2:0]          conv_sel_r;

    // synchronised pin levels
    logic [B_W-1:0]      pb_sync;
    logic [C_W-1:0]      pc_sync;
    logic [D_W-1:0]      pd_sync;

    // bus decode
    logic                setup;
    logic                access;
    logic                aligned;
    logic [5:0]          idx;
    logic                mapped;
    logic                wr_en;
    logic [7:0]          rd_val;
    logic [31:0]         prdata_r;
    logic                pslverr_r;

    // pin ownership
    logic [B_W-1:0]      b_force;
    logic [D_W-1:0]      d_alt_sel;
    logic [D_W-1:0]      d_alt_out;
    logic [D_W-1:0]      d_alt_oe;
    logic [D_W-1:0]      d_force;
    logic                ss_is_input;

    // pins pass through synchronisers before any read
    gpd_sync #(.W(B_W)) u_sync_b (
        .clk   (clk),
        .reset (reset),
        .d     (pb_in),
        .q     (pb_sync)
    );
    gpd_sync #(.W(C_W)) u_sync_c (
        .clk   (clk),
        .reset (reset),
        .d     (pc_in),
        .q     (pc_sync)
    );
    gpd_sync #(.W(D_W)) u_sync_d (
        .clk   (clk),
        .reset (reset),
        .d     (pd_in),
        .q     (pd_sync)
    );

    // apb decode; misaligned addresses count as unmapped
    assign setup   = psel & ~penable;
    assign access  = psel & penable;
    assign aligned = (paddr[1:0] == 2'b00) && ((paddr >> 8) == '0);  // shift stays legal when ADDR_W is 8
    assign idx     = paddr[7:2];
    always_comb begin
        unique case (idx)
            gpd_pkg::IDX_B_DATA, gpd_pkg::IDX_C_DATA, gpd_pkg::IDX_D_DATA,
            gpd_pkg::IDX_B_DIR, gpd_pkg::IDX_C_DIR, gpd_pkg::IDX_D_DIR,
            gpd_pkg::IDX_C_PULLUP, gpd_pkg::IDX_PERIPH,
            gpd_pkg::IDX_CONV: mapped = aligned;
            default:           mapped = 1'b0;
        endcase
    end
    assign wr_en  = access & pwrite & mapped;
    assign pready = 1'b1;  // zero wait states; read data is staged in setup

    // data latches carry no reset, as the port keeps them across it
    always_ff @(posedge clk) begin
        if (wr_en && idx == gpd_pkg::IDX_B_DATA) begin
            port_b_data_r <= pwdata[B_W-1:0];
        end
        if (wr_en && idx == gpd_pkg::IDX_C_DATA) begin
            port_c_data_r <= pwdata[C_W-1:0];
        end
        if (wr_en && idx == gpd_pkg::IDX_D_DATA) begin
            port_d_data_r <= pwdata[D_W-1:0];
        end
    end

    // direction and pull-up registers clear to all-input
    always_ff @(posedge clk) begin
        if (reset) begin
            port_b_direction_r     <= gpd_pkg::DIR_RESET[B_W-1:0];
            port_c_direction_r     <= gpd_pkg::DIR_RESET[C_W-1:0];
            port_d_direction_r     <= gpd_pkg::DIR_RESET[D_W-1:0];
            port_c_pullup_enable_r <= gpd_pkg::DIR_RESET[C_W-1:0];
        end else if (wr_en) begin
            unique case (idx)
                gpd_pkg::IDX_B_DIR:    port_b_direction_r     <= pwdata[B_W-1:0];
                gpd_pkg::IDX_C_DIR:    port_c_direction_r     <= pwdata[C_W-1:0];
                gpd_pkg::IDX_D_DIR:    port_d_direction_r     <= pwdata[D_W-1:0];
                gpd_pkg::IDX_C_PULLUP: port_c_pullup_enable_r <= pwdata[C_W-1:0];
                default: ;
            endcase
        end
    end

    // alternate-function and converter select
    always_ff @(posedge clk) begin
        if (reset) begin
            periph_r   <= gpd_pkg::PERIPH_RESET;
            conv_sel_r <= gpd_pkg::CONV_NONE;
        end else if (wr_en && idx == gpd_pkg::IDX_PERIPH) begin
            periph_r <= pwdata[7:0];
        end else if (wr_en && idx == gpd_pkg::IDX_CONV) begin
            conv_sel_r <= pwdata[2:0];
        end
    end

    // read value chosen per bit from direction; unused high bits read zero
    always_comb begin
        unique case (idx)
            gpd_pkg::IDX_B_DATA:   rd_val = gpd_pkg::read_mux({2'b00, port_b_direction_r},
                                                             {2'b00, port_b_data_r},
                                                             {2'b00, pb_sync});
            gpd_pkg::IDX_C_DATA:   rd_val = gpd_pkg::read_mux({6'h00, port_c_direction_r},
                                                             {6'h00, port_c_data_r},
                                                             {6'h00, pc_sync});
            gpd_pkg::IDX_D_DATA:   rd_val = gpd_pkg::read_mux({1'b0, port_d_direction_r},
                                                             {1'b0, port_d_data_r},
                                                             {1'b0, pd_sync});
            gpd_pkg::IDX_B_DIR:    rd_val = {2'b00, port_b_direction_r};
            gpd_pkg::IDX_C_DIR:    rd_val = {6'h00, port_c_direction_r};
            gpd_pkg::IDX_D_DIR:    rd_val = {1'b0, port_d_direction_r};
            gpd_pkg::IDX_C_PULLUP: rd_val = {6'h00, port_c_pullup_enable_r};
            gpd_pkg::IDX_PERIPH:   rd_val = periph_r;
            gpd_pkg::IDX_CONV:     rd_val = {5'h00, conv_sel_r};
            default:               rd_val = 8'h00;
        endcase
    end

    // read data and error staged in setup so they stand for the access cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            prdata_r  <= (mapped && !pwrite) ? {24'h00_0000, rd_val} : 32'h0000_0000;
            pslverr_r <= ~mapped;
        end
    end
    assign prdata  = prdata_r;
    assign pslverr = pslverr_r;

    // converter channel forces its port b pin to analog input
    always_comb begin
        b_force = '0;
        if (conv_sel_r < 3'(B_W)) begin
            b_force[conv_sel_r] = 1'b1;
        end
    end
    assign pb_analog_sel = b_force;

    // port b: no peripheral drive, no pull-up, high-z when input
    gpd_pin_mux #(.W(B_W)) u_mux_b (
        .dir      (port_b_direction_r),
        .latch    (port_b_data_r),
        .alt_sel  ('0),
        .alt_out  ('0),
        .alt_oe   ('0),
        .force_in (b_force),
        .pin_out  (pb_out),
        .pin_oe_n (pb_oe_n)
    );

    // port c: plain gpio
    gpd_pin_mux #(.W(C_W)) u_mux_c (
        .dir      (port_c_direction_r),
        .latch    (port_c_data_r),
        .alt_sel  ('0),
        .alt_out  ('0),
        .alt_oe   ('0),
        .force_in ('0),
        .pin_out  (pc_out),
        .pin_oe_n (pc_oe_n)
    );

    // pull-up only on input pins, dropped while driving
    assign pc_pullup_on = port_c_pullup_enable_r & ~port_c_direction_r;

    // port d ownership; direction bits never steer spi-owned pins
    assign spi_enable  = periph_r.spi_enable_bit;
    assign spi_master  = periph_r.spi_master_select_bit;
    assign ss_is_input = spi_enable & ~spi_master;
    always_comb begin
        d_alt_sel    = '0;
        d_alt_out    = '0;
        d_alt_oe     = '0;
        d_force      = '0;
        d_alt_sel[3:1] = {3{spi_enable}};
        d_alt_out[3:1] = spi_pin_out[3:1];
        d_alt_oe[3:1]  = spi_pin_oe[3:1];
        d_force[0]     = ss_is_input;
        d_alt_sel[4]   = periph_r.els_t1c0 != 2'b00;
        d_alt_sel[5]   = periph_r.els_t1c1 != 2'b00;
        d_alt_sel[6]   = periph_r.els_t2c0 != 2'b00;
        d_alt_out[6:4] = tim_pin_out;
        d_alt_oe[6:4]  = tim_pin_oe;
    end

    gpd_pin_mux #(.W(D_W)) u_mux_d (
        .dir      (port_d_direction_r),
        .latch    (port_d_data_r),
        .alt_sel  (d_alt_sel),
        .alt_out  (d_alt_out),
        .alt_oe   (d_alt_oe),
        .force_in (d_force),
        .pin_out  (pd_out),
        .pin_oe_n (pd_oe_n)
    );

    // peripherals see the synchronised levels; ss idles high unless slave
    assign pd_level           = pd_sync;
    assign spi_slave_select_n = ss_is_input ? pd_sync[0] : 1'b1;

    a_dir_reset: assert property (@(posedge clk) disable iff (reset)
        $fell(reset) |-> port_b_direction_r == '0 && port_c_direction_r == '0 && port_d_direction_r == '0)
        else $error("direction bits not cleared by reset");

    a_b_read_mux: assert property (@(posedge clk) disable iff (reset)
        setup && !pwrite && aligned && idx == gpd_pkg::IDX_B_DATA
        |=> prdata[5:0] == (($past(port_b_direction_r) & $past(port_b_data_r))
                          | (~$past(port_b_direction_r) & $past(pb_sync))) && prdata[31:6] == '0)
        else $error("port b read data wrong");

    a_d_latch_wr: assert property (@(posedge clk) disable iff (reset)
        access && pwrite && aligned && idx == gpd_pkg::IDX_D_DATA
        |=> port_d_data_r == $past(pwdata[6:0]))
        else $error("port d latch not written");

    a_b_drive_en: assert property (@(posedge clk) disable iff (reset)
        pb_oe_n == ~(port_b_direction_r & ~b_force) && (pb_analog_sel & ~pb_oe_n) == '0)
        else $error("port b drive enable wrong");

    a_pullup_off: assert property (@(posedge clk) disable iff (reset)
        (port_c_direction_r & pc_pullup_on) == '0
        && pc_pullup_on == (port_c_pullup_enable_r & ~port_c_direction_r))
        else $error("port c pull-up on a driven pin");

    a_spi_owns: assert property (@(posedge clk) disable iff (reset)
        spi_enable |-> pd_oe_n[3:1] == ~spi_pin_oe[3:1] && pd_out[3:1] == spi_pin_out[3:1])
        else $error("direction bits steer spi pins");

    a_ss_input: assert property (@(posedge clk) disable iff (reset)
        spi_enable && !spi_master |-> pd_oe_n[0] && spi_slave_select_n == pd_sync[0])
        else $error("slave select not an input");

    a_timer_pin: assert property (@(posedge clk) disable iff (reset)
        periph_r.els_t1c0 != 2'b00 |-> pd_out[4] == tim_pin_out[0] && pd_oe_n[4] == ~tim_pin_oe[0])
        else $error("timer channel does not own pin d4");

    a_unmapped_err: assert property (@(posedge clk) disable iff (reset)
        setup && !mapped |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not flagged");
endmodule

/* File: verif/gpd_pad_model.sv */
// pad model for one port: settles each wire from chip drive, board drive and pull-up
// assumes the bench drives a pin from the board only while the chip leaves it
`timescale 1ns/100ps
module gpd_pad_model #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] out,
    input  wire logic [W-1:0] oe_n,
    input  wire logic [W-1:0] pull,
    input  wire logic [W-1:0] ext_en,
    input  wire logic [W-1:0] ext_val,
    output logic      [W-1:0] lvl
);
    logic [W-1:0] float_r = '0;

    // an undriven pin wanders every cycle, so a stale level never reads as valid
    always_ff @(posedge clk) begin
        float_r <= ~float_r;
    end

    // chip drive wins, then the board, then the pull-up, else the wire floats
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (oe_n[i] == 1'b0) begin
                lvl[i] = out[i];
            end else if (ext_en[i] == 1'b1) begin
                lvl[i] = ext_val[i];
            end else if (pull[i] == 1'b1) begin
                lvl[i] = 1'b1;
            end else begin
                lvl[i] = float_r[i];
            end
        end
    end
endmodule

/* File: verif/testbench.sv */
// self-checking bench for the port b/c/d logic behind its apb slave
// assumes zero-wait apb answers and a pad model on every pin
`timescale 1ns/100ps
module testbench;
    logic        clk         = 1'b0;
    logic        reset       = 1'b1;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [7:0]  paddr       = 8'h00;
    logic [31:0] pwdata      = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [5:0]  pb_in, pb_out, pb_oe_n, pb_analog_sel;
    logic [1:0]  pc_in, pc_out, pc_oe_n, pc_pullup_on;
    logic [6:0]  pd_in, pd_out, pd_oe_n, pd_level;
    logic        spi_slave_select_n, spi_enable, spi_master;
    logic [3:0]  spi_pin_out = 4'h0, spi_pin_oe = 4'h0;
    logic [2:0]  tim_pin_out = 3'h0, tim_pin_oe = 3'h0;
    // board drivers standing in for whatever is wired to the pins
    logic [5:0]  b_en = 6'h00, b_val = 6'h00;
    logic [1:0]  c_en = 2'h0, c_val = 2'h0;
    logic [6:0]  d_en = 7'h00, d_val = 7'h00;
    logic [31:0] rd_v;
    logic        err_v;
    int          error_cnt   = 0;
    int          num_checks  = 0;

    always #5 clk = ~clk;

    gpd_ports #(.ADDR_W(8)) dut_u (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pb_in(pb_in), .pb_out(pb_out), .pb_oe_n(pb_oe_n), .pb_analog_sel(pb_analog_sel),
        .pc_in(pc_in), .pc_out(pc_out), .pc_oe_n(pc_oe_n), .pc_pullup_on(pc_pullup_on),
        .pd_in(pd_in), .pd_out(pd_out), .pd_oe_n(pd_oe_n), .spi_pin_out(spi_pin_out), .spi_pin_oe(spi_pin_oe),
        .tim_pin_out(tim_pin_out), .tim_pin_oe(tim_pin_oe), .pd_level(pd_level),
        .spi_slave_select_n(spi_slave_select_n), .spi_enable(spi_enable), .spi_master(spi_master));
    // port b and d have no pull-up on the board side of this model
    gpd_pad_model #(.W(6)) pad_b (.clk(clk), .out(pb_out), .oe_n(pb_oe_n), .pull(6'h00),
        .ext_en(b_en), .ext_val(b_val), .lvl(pb_in));
    gpd_pad_model #(.W(2)) pad_c (.clk(clk), .out(pc_out), .oe_n(pc_oe_n), .pull(pc_pullup_on),
        .ext_en(c_en), .ext_val(c_val), .lvl(pc_in));
    gpd_pad_model #(.W(7)) pad_d (.clk(clk), .out(pd_out), .oe_n(pd_oe_n), .pull(7'h00),
        .ext_en(d_en), .ext_val(d_val), .lvl(pd_in));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= {24'h00_0000, wd};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) error_cnt++;
        rd_v    = prdata;
        err_v   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // the #1 lets register-driven pin outputs settle before they are looked at
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        apb(1'b1, {idx, 2'b00}, d);
        #1;
    endtask

    task automatic rd(input logic [5:0] idx);
        apb(1'b0, {idx, 2'b00}, 8'h00);
    endtask

    task automatic t_reset;
        rd(gpd_pkg::IDX_B_DIR);
        check("b_dir reset", rd_v, 32'h0);
        rd(gpd_pkg::IDX_C_DIR);
        check("c_dir reset", rd_v, 32'h0);
        rd(gpd_pkg::IDX_D_DIR);
        check("d_dir reset", rd_v, 32'h0);
        check("oe_n reset", {17'h0, pb_oe_n, pc_oe_n, pd_oe_n}, 32'h7FFF);
        check("analog none", 32'(pb_analog_sel), 32'h0);
    endtask

    task automatic t_port_b;
        b_en  <= 6'h3F;
        b_val <= 6'h15;
        wr(gpd_pkg::IDX_B_DATA, 8'h2A); // latch loaded while still input
        rd(gpd_pkg::IDX_B_DATA);
        check("b pin read", rd_v, 32'h15);
        check("b hi-z", 32'(pb_oe_n), 32'h3F);
        // a pin change just before the read is still behind the synchroniser
        b_val <= 6'h1C;
        rd(gpd_pkg::IDX_B_DATA);
        check("b sync old", rd_v, 32'h15);
        rd(gpd_pkg::IDX_B_DATA);
        check("b sync new", rd_v, 32'h1C);
        b_en <= 6'h30;
        wr(gpd_pkg::IDX_B_DIR, 8'h0F);
        check("b oe_n mix", 32'(pb_oe_n), 32'h30);
        check("b out", 32'(pb_out), 32'h2A);
        rd(gpd_pkg::IDX_B_DATA);
        check("b mix read", rd_v, 32'h1A);
        b_en <= 6'h00;
        wr(gpd_pkg::IDX_B_DIR, 8'hFF); // all six pins made outputs; bits 7:6 are not stored
        rd(gpd_pkg::IDX_B_DIR);
        check("b_dir top bits", rd_v, 32'h3F);
        wr(gpd_pkg::IDX_CONV, 8'h02);
        check("analog sel", 32'(pb_analog_sel), 32'h04);
        check("analog oe_n", 32'(pb_oe_n), 32'h04);
        wr(gpd_pkg::IDX_CONV, 8'h07);
        check("analog off", 32'(pb_analog_sel), 32'h0);
    endtask

    task automatic t_port_c;
        wr(gpd_pkg::IDX_C_DATA, 8'h02);
        wr(gpd_pkg::IDX_C_PULLUP, 8'h03);
        check("c pull on", 32'(pc_pullup_on), 32'h3);
        // the pulled level must be two edges old at the setup edge
        @(posedge clk);
        rd(gpd_pkg::IDX_C_DATA);
        check("c pulled read", rd_v, 32'h3);
        wr(gpd_pkg::IDX_C_DIR, 8'h01);
        check("c pull out", 32'(pc_pullup_on), 32'h2);
        check("c oe_n", 32'(pc_oe_n), 32'h2);
        @(posedge clk);
        c_en  <= 2'h2;
        c_val <= 2'h1;  // bit 0 is chip-driven, so only bit 1 reaches the pin
        @(posedge clk);
        rd(gpd_pkg::IDX_C_DATA);
        check("c mix read", rd_v, 32'h0);
        rd(gpd_pkg::IDX_C_DIR);
        check("c_dir read", rd_v, 32'h1);
        wr(gpd_pkg::IDX_C_PULLUP, 8'h00);
        check("c pull off", 32'(pc_pullup_on), 32'h0);
    endtask

    task automatic t_port_d;
        wr(gpd_pkg::IDX_D_DATA, 8'hD5);
        d_en  <= 7'h70;
        d_val <= 7'h30;
        wr(gpd_pkg::IDX_D_DIR, 8'h0F);
        check("d oe_n", 32'(pd_oe_n), 32'h70);
        check("d out", 32'(pd_out), 32'h55);
        rd(gpd_pkg::IDX_D_DATA);
        check("d mix read", rd_v, 32'h35);
        // slave spi: d3..d1 follow the spi, d0 becomes the select input
        spi_pin_oe  <= 4'h2;
        spi_pin_out <= 4'h2;
        d_en        <= 7'h71;
        wr(gpd_pkg::IDX_PERIPH, 8'h01);
        check("spi oe_n", 32'(pd_oe_n), 32'h7D);
        check("spi out", 32'(pd_out[3:1]), 32'h1);
        repeat (3) @(posedge clk);
        #1;
        check("slave select", 32'(spi_slave_select_n), 32'h0);
        rd(gpd_pkg::IDX_D_DATA);
        check("spi read", rd_v, 32'h35);
        d_en <= 7'h70;
        wr(gpd_pkg::IDX_PERIPH, 8'h03);
        check("master ss", 32'(spi_slave_select_n), 32'h1);
        check("master oe_n", 32'(pd_oe_n), 32'h7C);
        @(posedge clk);
        d_en        <= 7'h60;
        tim_pin_oe  <= 3'h1;
        tim_pin_out <= 3'h6;  // unselected channels must not leak onto d5/d6
        wr(gpd_pkg::IDX_PERIPH, 8'h04);
        check("timer oe_n", 32'(pd_oe_n), 32'h60);
        check("timer out", 32'(pd_out), 32'h45);
    endtask

    // a second reset must clear directions but leave every latch alone
    task automatic t_reset_keep;
        @(posedge clk);
        reset <= 1'b1;
        repeat (4) @(posedge clk);
        reset      <= 1'b0;
        tim_pin_oe <= 3'h0;
        spi_pin_oe <= 4'h0;
        d_en       <= 7'h00;
        c_en       <= 2'h0;
        #1;
        check("d oe_n reset", 32'(pd_oe_n), 32'h7F);
        wr(gpd_pkg::IDX_C_DIR, 8'h03);
        rd(gpd_pkg::IDX_C_DATA);
        check("c latch kept", rd_v, 32'h2);
        wr(gpd_pkg::IDX_D_DIR, 8'h7F);
        rd(gpd_pkg::IDX_D_DATA);
        check("d latch kept", rd_v, 32'h55);
    endtask

    task automatic t_unmapped;
        apb(1'b1, 8'h20, 8'hFF);
        check("unmapped wr err", 32'(err_v), 32'h1);
        apb(1'b0, 8'h20, 8'h00);
        check("unmapped rd err", 32'(err_v), 32'h1);
        check("unmapped rd data", rd_v, 32'h0);
        apb(1'b0, 8'h05, 8'h00);
        check("misaligned err", 32'(err_v), 32'h1);
        rd(gpd_pkg::IDX_D_DIR);
        check("mapped err", 32'(err_v), 32'h0);
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_port_b();
        t_port_c();
        t_port_d();
        t_reset_keep();
        t_unmapped();
        final_report();
    end

    // watchdog: the run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        final_report();
    end
endmodule
